// File: tb_tim_tx_irq_mod.sv
`include "tim_cfg.svh"
`default_nettype none
module tb_tim_tx_irq_mod;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] address = 16'h0000;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h00000000;
    logic [31:0] readdata, q;
    logic waitrequest, txDoneValid, txDoneStatusReq, txDoneReportSent, txDoneDelayEn;
    logic burstEnable, txWrittenBackCause, descriptorLowCause, writeBackReq, prefetchOk;
    logic [7:0] onChipCount, writeBackCount;
    logic [15:0] hostAvailCount, availCount;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    int nCause = 0;
    int nLow = 0;
    int nWb = 0;
    int b, c;
    tim_tx_irq_mod i_tim_tx_irq_mod (.clk(clk), .rst_b(rst_b), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(4'hf),
        .readdata(readdata), .waitrequest(waitrequest), .txDoneValid(txDoneValid),
        .txDoneStatusReq(txDoneStatusReq), .txDoneReportSent(txDoneReportSent),
        .txDoneDelayEn(txDoneDelayEn), .burstEnable(burstEnable),
        .onChipCount(onChipCount), .hostAvailCount(hostAvailCount),
        .availCount(availCount), .txWrittenBackCause(txWrittenBackCause),
        .descriptorLowCause(descriptorLowCause), .writeBackReq(writeBackReq),
        .writeBackCount(writeBackCount), .prefetchOk(prefetchOk));
    tim_ring_model i_tim_ring_model (.clk(clk), .txDoneValid(txDoneValid),
        .txDoneStatusReq(txDoneStatusReq), .txDoneReportSent(txDoneReportSent),
        .txDoneDelayEn(txDoneDelayEn), .burstEnable(burstEnable),
        .onChipCount(onChipCount), .hostAvailCount(hostAvailCount),
        .availCount(availCount));
    always #12.5 clk = ~clk;
    task automatic end_of_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Pulses are counted so that a scenario can check how many arrived in a window.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (txWrittenBackCause === 1'b1) nCause <= nCause + 1;
        if (descriptorLowCause === 1'b1) nLow <= nLow + 1;
        if (writeBackReq === 1'b1) nWb <= nWb + 1;
        if (cycles == 20000) begin
            fails++;
            end_of_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // The request stands until waitrequest is sampled low at a rising edge.
    // Read data is taken at that same edge; a hang is ended by the cycle ceiling.
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        read <= ~w;
        write <= w;
        writedata <= d;
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [15:0] a);
        bus(1'b0, a, 32'h00000000);
    endtask
    task automatic send(input logic sr, input logic rsp, input logic de);
        i_tim_ring_model.send(sr, rsp, de);
    endtask
    task automatic counts(input logic [7:0] oc, input logic [15:0] ha,
                          input logic [15:0] av, input logic be);
        i_tim_ring_model.setCounts(oc, ha, av, be);
    endtask
    task automatic pf(input logic [31:0] ctl, input logic [7:0] oc, input logic [15:0] ha,
                      input logic exp);
        wr(`TIM_ADDR_CTRL, ctl);
        counts(oc, ha, 16'h0000, 1'b0);
        cyc(3);
        chk("prefetch", {31'h0, prefetchOk}, {31'h0, exp});
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        cyc(2);
        rd(`TIM_ADDR_DELAY);
        chk("delay reset", q, 32'h00000000);
        rd(`TIM_ADDR_CTRL);
        chk("ctrl reset", q, 32'h00000000);
        rd(`TIM_ADDR_ABS);
        chk("abs reset", q, 32'h00000000);
        wr(16'h3840, 32'h1234abcd);
        rd(16'h3840);
        chk("unmapped", q, 32'h00000000);
        wr(`TIM_ADDR_CTRL, 32'hffffffff);
        rd(`TIM_ADDR_CTRL);
        chk("ctrl", q, 32'hff3f3f3f);
        wr(`TIM_ADDR_ABS, 32'hffff0007);
        rd(`TIM_ADDR_ABS);
        chk("abs", q, 32'h00000007);
        wr(`TIM_ADDR_ABS, 32'h00000000);
        wr(`TIM_ADDR_CTRL, 32'h00000000);
        b = nCause;
        c = nWb;
        wr(`TIM_ADDR_DELAY, 32'hffff0003);
        cyc(3);
        chk("flush cause", nCause - b, 1);
        chk("flush writeback", nWb - c, 1);
        rd(`TIM_ADDR_DELAY);
        chk("delay", q, 32'h00000003);
        b = nCause;
        wr(`TIM_ADDR_DELAY, 32'h00000003);
        cyc(3);
        chk("flag zero", nCause - b, 0);
        b = nCause;
        send(1'b1, 1'b0, 1'b0);
        cyc(2);
        chk("immediate", nCause - b, 1);
        send(1'b0, 1'b1, 1'b0);
        cyc(2);
        chk("report sent", nCause - b, 2);
        b = nCause;
        send(1'b1, 1'b0, 1'b1);
        rd(`TIM_ADDR_STATUS);
        chk("status running", q, 32'h00000001);
        cyc(67);
        send(1'b1, 1'b0, 1'b1);
        cyc(75);
        chk("delay restart", nCause - b, 0);
        cyc(50);
        chk("delay expiry", nCause - b, 1);
        b = nCause;
        send(1'b0, 1'b0, 1'b1);
        cyc(200);
        chk("no report", nCause - b, 0);
        wr(`TIM_ADDR_DELAY, 32'h00000014);
        wr(`TIM_ADDR_ABS, 32'h00000002);
        b = nCause;
        send(1'b1, 1'b0, 1'b1);
        cyc(30);
        send(1'b1, 1'b0, 1'b1);
        cyc(60);
        chk("abs expiry", nCause - b, 1);
        cyc(900);
        chk("delay halted", nCause - b, 1);
        b = nCause;
        send(1'b1, 1'b0, 1'b1);
        cyc(5);
        send(1'b1, 1'b0, 1'b0);
        cyc(900);
        chk("immediate halts", nCause - b, 1);
        wr(`TIM_ADDR_ABS, 32'h00000000);
        wr(`TIM_ADDR_CTRL, 32'h01020000);
        wr(`TIM_ADDR_DELAY, 32'h80000014);
        // The flush pulse lands after the write is taken, so it must pass before the baseline.
        cyc(2);
        c = nWb;
        repeat (3) send(1'b0, 1'b0, 1'b0);
        send(1'b1, 1'b0, 1'b0);
        cyc(3);
        chk("before first report", nWb - c, 0);
        send(1'b1, 1'b0, 1'b0);
        cyc(3);
        chk("threshold", nWb - c, 1);
        chk("wb count", {24'h0, writeBackCount}, 32'h00000002);
        counts(8'h00, 16'h0000, 16'h0000, 1'b1);
        wr(`TIM_ADDR_DELAY, 32'h80000014);
        cyc(2);
        c = nWb;
        send(1'b1, 1'b0, 1'b0);
        send(1'b0, 1'b0, 1'b0);
        cyc(3);
        chk("burst", nWb - c, 1);
        wr(`TIM_ADDR_CTRL, 32'h02000000);
        counts(8'h00, 16'h0000, 16'h0009, 1'b0);
        cyc(2);
        b = nLow;
        counts(8'h00, 16'h0000, 16'h0008, 1'b0);
        cyc(3);
        chk("low", nLow - b, 1);
        counts(8'h00, 16'h0000, 16'h0007, 1'b0);
        cyc(3);
        chk("low once", nLow - b, 1);
        wr(`TIM_ADDR_CTRL, 32'h00000000);
        counts(8'h00, 16'h0000, 16'h0009, 1'b0);
        cyc(2);
        b = nLow;
        counts(8'h00, 16'h0000, 16'h0008, 1'b0);
        cyc(3);
        chk("low off", nLow - b, 0);
        pf(32'h01000204, 8'h03, 16'h0002, 1'b1);
        pf(32'h01000204, 8'h04, 16'h0002, 1'b0);
        pf(32'h01000204, 8'h03, 16'h0001, 1'b0);
        pf(32'h00000101, 8'h03, 16'h0004, 1'b1);
        pf(32'h00000101, 8'h03, 16'h0003, 1'b0);
        pf(32'h00000101, 8'h04, 16'h0004, 1'b0);
        end_of_test();
    end
endmodule
`default_nettype wire

// File: tim_cfg.svh
`ifndef TIM_CFG_SVH
`define TIM_CFG_SVH
// Register byte addresses.
`define TIM_ADDR_DELAY 16'h3820
`define TIM_ADDR_CTRL 16'h3828
`define TIM_ADDR_ABS 16'h382c
`define TIM_ADDR_STATUS 16'h3830
// Field positions.
`define TIM_FLUSH_BIT 31
`define TIM_PTH_LSB 0
`define TIM_HTH_LSB 8
`define TIM_WTH_LSB 16
`define TIM_GRANULARITY_BIT_BIT 24
`define TIM_LW_LSB 25
`define TIM_CTRL_MASK 32'hff3f3f3f
// Reset values.
`define TIM_DELAY_RST 16'h0000
`define TIM_ABS_RST 16'h0000
`define TIM_CTRL_RST 32'h00000000
// Timer tick of 1.024 us derived from a 25 ns clock, rounded down.
`define TIM_TICK_PS 1024000
`define TIM_CLK_PS 25000
`define TIM_TICK_CYCLES (`TIM_TICK_PS / `TIM_CLK_PS)
// Low water field unit in descriptors.
`define TIM_LW_UNIT_SHIFT 3
`endif

// File: tim_pkg.sv
`default_nettype none
package tim_pkg;
    typedef enum logic {
        TIM_HALT,
        TIM_COUNT
    } tim_timer_e;
    typedef logic [15:0] tim_ticks_t;
endpackage
`default_nettype wire

// File: tim_ring_model.sv
`default_nettype none
module tim_ring_model (
    input wire logic clk,
    output logic txDoneValid,
    output logic txDoneStatusReq,
    output logic txDoneReportSent,
    output logic txDoneDelayEn,
    output logic burstEnable,
    output logic [7:0] onChipCount,
    output logic [15:0] hostAvailCount,
    output logic [15:0] availCount
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        txDoneValid = 1'b0;
        txDoneStatusReq = 1'b0;
        txDoneReportSent = 1'b0;
        txDoneDelayEn = 1'b0;
        burstEnable = 1'b0;
        onChipCount = 8'h00;
        hostAvailCount = 16'h0000;
        availCount = 16'h0000;
    end
    // Flags mean nothing between completions, so they flip there to expose stale use.
    task automatic send(input logic sr, input logic rsp, input logic de);
        @(posedge clk);
        txDoneValid <= 1'b1;
        txDoneStatusReq <= sr;
        txDoneReportSent <= rsp;
        txDoneDelayEn <= de;
        @(posedge clk);
        txDoneValid <= 1'b0;
        txDoneStatusReq <= ~sr;
        txDoneReportSent <= ~rsp;
        txDoneDelayEn <= ~de;
    endtask
    task automatic setCounts(input logic [7:0] oc, input logic [15:0] ha,
                             input logic [15:0] av, input logic be);
        @(posedge clk);
        onChipCount <= oc;
        hostAvailCount <= ha;
        availCount <= av;
        burstEnable <= be;
    endtask
endmodule
`default_nettype wire

// File: tim_tx_irq_mod.sv
// Implementation choice: register access over Avalon-MM.
`include "tim_cfg.svh"
`default_nettype none
// Notes on behaviour
// - Delay timer applies only to descriptors with status report and delay enable set.
// - Qualifying completion starts the delay countdown; expiry raises written-back cause.
// - A further qualifying completion before expiry reloads and restarts the delay timer.
// - Immediate interrupt, or absolute expiry with no qualifying completion that cycle, cancels delay timer, reloaded and halted.
// - Status report with delay enable clear raises the interrupt at once.
// - Flush write expires delay timer, writes back pending descriptors, raises cause.
// - Flush flag self clears, reads zero, writing zero does nothing.
// - Delay value is sixteen bits in 1.024 us ticks.
// - Absolute value is sixteen bits in ticks; zero disables absolute delay.
// - Absolute timer starts on qualifying completion, not restarted, expiry raises cause.
// - Immediate interrupt or delayed expiry halts the absolute timer.
// - Ready count accumulates only from the first status-report descriptor.
// - With bursting enabled, non-report descriptors also join the write-back.
// - Low cause when available count falls from eight times field plus one.
// - Low water field zero disables the descriptor-low cause.
// - Prefetch allowed when on-chip below prefetch and host at least host threshold.
// - Granularity bit selects cache lines when zero, descriptors when one.
module tim_tx_irq_mod #(
    parameter int DESC_PER_LINE_SHIFT = 2,
    parameter int COUNT_W = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [15:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic txDoneValid,
    input wire logic txDoneStatusReq,
    input wire logic txDoneReportSent,
    input wire logic txDoneDelayEn,
    input wire logic burstEnable,
    input wire logic [COUNT_W-1:0] onChipCount,
    input wire logic [15:0] hostAvailCount,
    input wire logic [15:0] availCount,
    output logic txWrittenBackCause,
    output logic descriptorLowCause,
    output logic writeBackReq,
    output logic [COUNT_W-1:0] writeBackCount,
    output logic prefetchOk
);

    function automatic logic [31:0] beMerge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Threshold fields are six bits; in cache line units they are scaled up.
    function automatic logic [15:0] toDesc(
        input logic [5:0] field,
        input logic granularity_bit
    );
        logic [15:0] w;
        w = {10'h000, field};
        return granularity_bit ? w : 16'(w << DESC_PER_LINE_SHIFT);
    endfunction

    // Bus slave: one wait cycle, then the request is taken.
    logic ackQ;
    logic reqOn;
    logic rdTake;
    logic wrTake;
    logic hitDelay;
    logic hitCtrl;
    logic hitAbs;
    logic hitStatus;
    logic [31:0] rdMux;

    assign reqOn = read | write;
    assign waitrequest = reqOn & ~ackQ;
    assign rdTake = read & ~waitrequest;
    assign wrTake = write & ~waitrequest;
    assign hitDelay = address == `TIM_ADDR_DELAY;
    assign hitCtrl = address == `TIM_ADDR_CTRL;
    assign hitAbs = address == `TIM_ADDR_ABS;
    assign hitStatus = address == `TIM_ADDR_STATUS;

    logic [15:0] dlyValQ;
    logic [15:0] absValQ;
    logic [31:0] ctrlQ;
    logic [31:0] delayWr;
    logic [31:0] absWr;
    logic [31:0] ctrlWr;
    logic flushHit;

    assign delayWr = beMerge({16'h0000, dlyValQ}, writedata, byteenable);
    assign absWr = beMerge({16'h0000, absValQ}, writedata, byteenable);
    assign ctrlWr = beMerge(ctrlQ, writedata, byteenable) & `TIM_CTRL_MASK;
    // The flush flag is never stored, so it always reads as zero.
    assign flushHit = wrTake & hitDelay & byteenable[3] & writedata[`TIM_FLUSH_BIT];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ackQ <= 1'b0;
        end else begin
            ackQ <= reqOn & ~ackQ;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dlyValQ <= `TIM_DELAY_RST;
            absValQ <= `TIM_ABS_RST;
            ctrlQ <= `TIM_CTRL_RST;
        end else begin
            if (wrTake && hitDelay) begin
                dlyValQ <= delayWr[15:0];
            end
            if (wrTake && hitAbs) begin
                absValQ <= absWr[15:0];
            end
            if (wrTake && hitCtrl) begin
                ctrlQ <= ctrlWr;
            end
        end
    end

    // Control fields.
    logic [5:0] pthField;
    logic [5:0] hthField;
    logic [5:0] wthField;
    logic granBit;
    logic [6:0] lwField;
    logic [15:0] pthDesc;
    logic [15:0] hthDesc;
    logic [15:0] wthDesc;

    assign pthField = ctrlQ[`TIM_PTH_LSB +: 6];
    assign hthField = ctrlQ[`TIM_HTH_LSB +: 6];
    assign wthField = ctrlQ[`TIM_WTH_LSB +: 6];
    assign granBit = ctrlQ[`TIM_GRANULARITY_BIT_BIT];
    assign lwField = ctrlQ[`TIM_LW_LSB +: 7];
    assign pthDesc = toDesc(pthField, granBit);
    assign hthDesc = toDesc(hthField, granBit);
    assign wthDesc = toDesc(wthField, granBit);

    // Shared tick prescaler, free running.
    localparam logic [7:0] TICK_LAST = 8'(`TIM_TICK_CYCLES - 1);
    logic [7:0] preQ;
    logic tickQ;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            preQ <= 8'h00;
            tickQ <= 1'b0;
        end else begin
            preQ <= (preQ == TICK_LAST) ? 8'h00 : preQ + 8'h01;
            tickQ <= preQ == TICK_LAST;
        end
    end

    // Completion events.
    logic qualDone;
    logic immDone;
    assign qualDone = txDoneValid & txDoneStatusReq & txDoneDelayEn;
    assign immDone = txDoneValid & (txDoneStatusReq | txDoneReportSent)
        & ~txDoneDelayEn;

    tim_pkg::tim_timer_e dlyStQ;
    tim_pkg::tim_timer_e absStQ;
    tim_pkg::tim_ticks_t dlyCntQ;
    tim_pkg::tim_ticks_t absCntQ;
    logic dlyExp;
    logic absExp;
    logic fire;

    // A count of one or zero expires on the next tick, so a zero delay value still fires.
    assign dlyExp = (dlyStQ == tim_pkg::TIM_COUNT) & tickQ & (dlyCntQ <= 16'h0001);
    assign absExp = (absStQ == tim_pkg::TIM_COUNT) & tickQ & (absCntQ <= 16'h0001);
    assign fire = immDone | flushHit | dlyExp | absExp;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dlyStQ <= tim_pkg::TIM_HALT;
            dlyCntQ <= 16'h0000;
        end else begin
            case (dlyStQ)
                tim_pkg::TIM_HALT: begin
                    dlyCntQ <= dlyValQ;
                    if (qualDone && !flushHit) begin
                        dlyStQ <= tim_pkg::TIM_COUNT;
                    end
                end
                tim_pkg::TIM_COUNT: begin
                    if (immDone || flushHit) begin
                        dlyStQ <= tim_pkg::TIM_HALT;
                        dlyCntQ <= dlyValQ;
                    end else if (qualDone) begin
                        dlyCntQ <= dlyValQ;
                    end else if (absExp || dlyExp) begin
                        dlyStQ <= tim_pkg::TIM_HALT;
                        dlyCntQ <= dlyValQ;
                    end else if (tickQ) begin
                        dlyCntQ <= dlyCntQ - 16'h0001;
                    end
                end
                default: begin
                    dlyStQ <= tim_pkg::TIM_HALT;
                end
            endcase
        end
    end

    // The absolute timer is not restarted by later completions while counting.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            absStQ <= tim_pkg::TIM_HALT;
            absCntQ <= 16'h0000;
        end else begin
            case (absStQ)
                tim_pkg::TIM_HALT: begin
                    absCntQ <= absValQ;
                    if (qualDone && absValQ != 16'h0000) begin
                        absStQ <= tim_pkg::TIM_COUNT;
                    end
                end
                tim_pkg::TIM_COUNT: begin
                    if (immDone || flushHit || dlyExp || absExp) begin
                        absStQ <= tim_pkg::TIM_HALT;
                    end else if (tickQ) begin
                        absCntQ <= absCntQ - 16'h0001;
                    end
                end
                default: begin
                    absStQ <= tim_pkg::TIM_HALT;
                end
            endcase
        end
    end

    // Write-back accounting.
    logic wbStartedQ;
    logic [COUNT_W-1:0] readyQ;
    logic countIt;
    logic [COUNT_W-1:0] readyNext;
    logic wbNow;

    assign countIt = txDoneValid & (txDoneStatusReq | (burstEnable & wbStartedQ));
    assign readyNext = countIt ? readyQ + COUNT_W'(1) : readyQ;
    assign wbNow = flushHit
        | (readyNext != '0 && 16'(readyNext) >= wthDesc);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wbStartedQ <= 1'b0;
            readyQ <= '0;
            writeBackReq <= 1'b0;
            writeBackCount <= '0;
        end else begin
            writeBackReq <= wbNow;
            writeBackCount <= wbNow ? readyNext : writeBackCount;
            if (wbNow) begin
                readyQ <= '0;
                wbStartedQ <= 1'b0;
            end else begin
                readyQ <= readyNext;
                wbStartedQ <= wbStartedQ | (txDoneValid & txDoneStatusReq);
            end
        end
    end

    // Descriptor-low detection on a single step down across the level.
    logic [15:0] lwLevel;
    logic [15:0] prevAvailQ;
    logic lowHit;

    assign lwLevel = 16'({9'h000, lwField} << `TIM_LW_UNIT_SHIFT);
    assign lowHit = (lwField != 7'h00)
        & (prevAvailQ == lwLevel + 16'h0001) & (availCount == lwLevel);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prevAvailQ <= 16'h0000;
            descriptorLowCause <= 1'b0;
            txWrittenBackCause <= 1'b0;
            prefetchOk <= 1'b0;
        end else begin
            prevAvailQ <= availCount;
            descriptorLowCause <= lowHit;
            txWrittenBackCause <= fire;
            prefetchOk <= (16'(onChipCount) < pthDesc)
                & (hostAvailCount >= hthDesc);
        end
    end

    // Status word shows live timer state and the ready count.
    logic [31:0] statusWord;
    assign statusWord = {8'h00, 8'(readyQ), 14'h0000,
        absStQ == tim_pkg::TIM_COUNT, dlyStQ == tim_pkg::TIM_COUNT};

    assign rdMux = hitDelay ? {16'h0000, dlyValQ}
        : hitCtrl ? ctrlQ
        : hitAbs ? {16'h0000, absValQ}
        : hitStatus ? statusWord
        : 32'h00000000;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            readdata <= 32'h00000000;
        end else if (read && !ackQ) begin
            readdata <= rdMux;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    property p_imm_fires;
        immDone |=> txWrittenBackCause;
    endproperty
    a_imm_fires: assert property (p_imm_fires) else $error("immediate cause missing");

    property p_imm_halts;
        immDone |=> dlyStQ == tim_pkg::TIM_HALT && absStQ == tim_pkg::TIM_HALT
            && dlyCntQ == $past(dlyValQ);
    endproperty
    a_imm_halts: assert property (p_imm_halts) else $error("timers not halted");

    property p_flush;
        flushHit |=> txWrittenBackCause && writeBackReq && dlyStQ == tim_pkg::TIM_HALT;
    endproperty
    a_flush: assert property (p_flush) else $error("flush had no effect");

    property p_flush_reads_zero;
        (read && ackQ && hitDelay) |-> readdata[`TIM_FLUSH_BIT] == 1'b0;
    endproperty
    a_flush_reads_zero: assert property (p_flush_reads_zero) else $error("flush read one");

    property p_reload;
        (qualDone && !flushHit) |=> dlyStQ == tim_pkg::TIM_COUNT
            && dlyCntQ == $past(dlyValQ);
    endproperty
    a_reload: assert property (p_reload) else $error("delay not reloaded");

    property p_abs_zero;
        (absStQ == tim_pkg::TIM_HALT && absValQ == 16'h0000) |=> absStQ == tim_pkg::TIM_HALT;
    endproperty
    a_abs_zero: assert property (p_abs_zero) else $error("absolute ran at zero");

    property p_abs_no_restart;
        (absStQ == tim_pkg::TIM_COUNT && !tickQ && qualDone) |=> absCntQ == $past(absCntQ);
    endproperty
    a_abs_no_restart: assert property (p_abs_no_restart) else $error("absolute restarted");

    property p_dly_halts_abs;
        (dlyExp && !qualDone) |=> absStQ == tim_pkg::TIM_HALT;
    endproperty
    a_dly_halts_abs: assert property (p_dly_halts_abs) else $error("absolute not halted");

    property p_low;
        descriptorLowCause |-> $past(lwField) != 7'h00
            && $past(availCount) == 16'({9'h000, $past(lwField)} << 3);
    endproperty
    a_low: assert property (p_low) else $error("bad descriptor low");

    property p_prefetch;
        prefetchOk |-> 16'($past(onChipCount)) < $past(pthDesc);
    endproperty
    a_prefetch: assert property (p_prefetch) else $error("prefetch above threshold");

    property p_tick_gap;
        tickQ |=> !tickQ [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick too frequent");

endmodule
`default_nettype wire
